// >>> core/bcs_pkg.sv
// package for the bus cycle status and control block
package bcs_pkg;
    // bus cycle status codes, status two, one, zero
    typedef enum logic [2:0] {
        BCS_ST_INTA  = 3'h0,
        BCS_ST_IORD  = 3'h1,
        BCS_ST_IOWR  = 3'h2,
        BCS_ST_HALT  = 3'h3,
        BCS_ST_FETCH = 3'h4,
        BCS_ST_MEMRD = 3'h5,
        BCS_ST_MEMWR = 3'h6,
        BCS_ST_IDLE  = 3'h7
    } bcs_status_t;

    // bus cycle request from the execution side
    typedef struct packed {
        logic        start;
        bcs_status_t kind;
        logic [19:0] addr;
        logic        dma;
        logic        lcs_ucs;
        logic        quiet;
    } bcs_req_t;

    // register offsets and fields
    localparam logic [7:0]  BCS_OFF_AUX      = 8'h00;
    localparam logic [7:0]  BCS_OFF_PBASE    = 8'h04;
    localparam logic [7:0]  BCS_OFF_STAT     = 8'h08;
    localparam int          BCS_PIN_ROLE_BIT = 7;
    localparam logic [15:0] BCS_AUX_RST      = 16'h0000;
    localparam logic [15:0] BCS_PBASE_RST    = 16'h0000;
    localparam logic [19:0] BCS_RESET_VEC    = 20'hF_FFF0;
    localparam int          BCS_REGION_BITS  = 8;
    localparam logic [2:0]  BCS_REGION_FIVE  = 3'h5;
    localparam logic [2:0]  BCS_REGION_SIX   = 3'h6;
    // timing
    localparam int          BCS_CLK_NS       = 10;
    localparam int          BCS_RST_MIN_NS   = 1000000;
    localparam int          BCS_RST_MIN_CYC  = (BCS_RST_MIN_NS + BCS_CLK_NS - 1) / BCS_CLK_NS;
    localparam int          BCS_FETCH_CYC    = 7;
    localparam int          BCS_STRAP_DLY    = 1;
endpackage : bcs_pkg

// >>> core/bcs_bus_ctrl.sv
// bus cycle status, peripheral selects, read strobe and reset straps
`timescale 1ns/1ps
module bcs_bus_ctrl
    import bcs_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [15:0]      reg_rdata_o,
    // cycle requests and conditions
    input  bcs_req_t         req_i,
    input  wire logic        hold_i,
    input  wire logic        emu_tristate_i,
    input  wire logic        refresh_i,
    input  wire logic        psram_mode_i,
    input  wire logic        srdy_i,
    input  wire logic        ardy_i,
    input  wire logic        aden_strap_i,
    input  wire logic        half_clock_strap_i,
    // status outputs
    output logic             busy_o,
    output logic             fetch_start_o,
    output logic [19:0]      fetch_addr_o,
    output logic             half_clock_o,
    output logic             addr_quiet_o,
    // pins, output enables low while driven
    output logic             periph_select_five_o,
    output logic             periph_select_six_o,
    output logic             ps5_oe_n_o,
    output logic             ps6_oe_n_o,
    output logic             rd_n_o,
    output logic             rd_oe_n_o,
    output logic             ad_float_o,
    output logic [2:0]       status_low_o,
    output logic             status_oe_n_o,
    output logic             dma_cycle_flag_o,
    output logic             dma_oe_n_o,
    output logic             dram_refresh_two_low_o,
    output logic             refresh_two_oe_n_o
);
    // bus states idle and T1..T4, one-hot
    typedef enum logic [4:0] {
        BCS_IDLE = 5'b0_0001,
        BCS_T1   = 5'b0_0010,
        BCS_T2   = 5'b0_0100,
        BCS_T3   = 5'b0_1000,
        BCS_T4   = 5'b1_0000
    } bcs_state_t;

    bcs_state_t  st_q;
    bcs_req_t    cyc_q;
    logic [1:0]  rst_sync_q;
    logic        in_rst;
    logic [2:0]  fetch_cnt_q;
    logic        fetch_pend_q;
    logic        strap_dly_q;
    logic        aden_q;
    logic        half_q;
    logic [15:0] aux_q;
    logic [15:0] pbase_q;
    logic        lat_a1_q;
    logic        lat_a2_q;
    logic        ready;
    logic        sel5;
    logic        sel6;

    // the synchroniser eats two edges and the counter one, so it stops three short
    localparam logic [2:0] FETCH_LAST = 3'(BCS_FETCH_CYC - 3);

    // the three-bit counter cannot serve a longer or shorter first-fetch delay
    if (BCS_FETCH_CYC < 3 || BCS_FETCH_CYC > 10) begin : g_fetch_chk
        $error("first fetch delay outside what the counter can count");
    end

    // region decode used for both selects
    function automatic logic in_region(input logic [19:0] a, input logic [15:0] base,
                                       input logic [2:0] idx);
        logic [19:0] off;
        off = a - {base[9:0], 10'h000};
        in_region = (off[19:11] == 9'h000) && (off[10:8] == idx);
    endfunction : in_region

    // reset synchroniser; release is delayed, assertion is immediate
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rst_sync_q <= 2'b11;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b0};
        end
    end
    assign in_rst = rst_sync_q[1];

    // straps: half clock at release, address enable one clock later
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            strap_dly_q <= 1'b0;
            aden_q      <= 1'b0;
            half_q      <= 1'b0;
        end else begin
            strap_dly_q <= in_rst;
            if (in_rst) begin
                half_q <= ~half_clock_strap_i;
            end
            if (strap_dly_q && !in_rst) begin
                aden_q <= aden_strap_i;
            end
        end
    end
    assign half_clock_o = half_q;

    // first fetch launch, seven edges after external release approximate 6.5 periods
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            fetch_cnt_q  <= 3'h0;
            fetch_pend_q <= 1'b1;
        end else if (in_rst) begin
            fetch_cnt_q  <= 3'h0;
            fetch_pend_q <= 1'b1;
        end else if (fetch_pend_q) begin
            fetch_cnt_q <= fetch_cnt_q + 3'h1;
            if (fetch_cnt_q == FETCH_LAST) begin
                fetch_pend_q <= 1'b0;
            end
        end
    end
    assign fetch_start_o = fetch_pend_q && !in_rst
                           && (fetch_cnt_q == FETCH_LAST);
    assign fetch_addr_o  = BCS_RESET_VEC;

    // register writes; pin role bit steers the shared select pins
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            aux_q   <= BCS_AUX_RST;
            pbase_q <= BCS_PBASE_RST;
        end else if (in_rst) begin
            aux_q   <= BCS_AUX_RST;
            pbase_q <= BCS_PBASE_RST;
        end else if (reg_wr_i) begin
            if (reg_addr_i == BCS_OFF_AUX) begin
                aux_q <= reg_wdata_i;
            end else if (reg_addr_i == BCS_OFF_PBASE) begin
                pbase_q <= reg_wdata_i;
            end
        end
    end

    // register reads, data one cycle later, unmapped read as zero
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            if (reg_addr_i == BCS_OFF_AUX) begin
                reg_rdata_o <= aux_q;
            end else if (reg_addr_i == BCS_OFF_PBASE) begin
                reg_rdata_o <= pbase_q;
            end else if (reg_addr_i == BCS_OFF_STAT) begin
                reg_rdata_o <= {9'h000, aden_q, half_q, st_q};
            end else begin
                reg_rdata_o <= 16'h0000;
            end
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // srdy is used as is, the partner keeps it synchronous
    assign ready = srdy_i || ardy_i;

    // bus state machine
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st_q  <= BCS_IDLE;
            cyc_q <= '0;
        end else if (in_rst) begin
            st_q  <= BCS_IDLE;
            cyc_q <= '0;
        end else begin
            case (st_q)
                BCS_IDLE: begin
                    if (req_i.start && !hold_i) begin
                        st_q  <= BCS_T1;
                        cyc_q <= req_i;
                    end
                end
                BCS_T1: begin
                    st_q <= BCS_T2;
                end
                BCS_T2: begin
                    st_q <= BCS_T3;
                end
                BCS_T3: begin
                    if (ready) begin
                        st_q <= BCS_T4;
                    end
                end
                BCS_T4: begin
                    st_q  <= BCS_IDLE;
                    cyc_q <= '0;
                end
                default: begin
                    st_q <= BCS_IDLE;
                end
            endcase
        end
    end
    assign busy_o = (st_q != BCS_IDLE);

    // address latch; frozen in hold so the pins keep their value
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            lat_a1_q <= 1'b0;
            lat_a2_q <= 1'b0;
        end else if (st_q == BCS_T1 && !hold_i) begin
            lat_a1_q <= cyc_q.addr[1];
            lat_a2_q <= cyc_q.addr[2];
        end
    end

    // selects only inside a live cycle that matches
    assign sel5 = busy_o && in_region(cyc_q.addr, pbase_q, BCS_REGION_FIVE);
    assign sel6 = busy_o && in_region(cyc_q.addr, pbase_q, BCS_REGION_SIX);

    // shared pins: selects or latched address bits; reset wins so both pins stay high
    always_comb begin
        if (in_rst) begin
            periph_select_five_o = 1'b1;
            periph_select_six_o  = 1'b1;
        end else if (!aux_q[BCS_PIN_ROLE_BIT]) begin
            periph_select_five_o = lat_a1_q;
            periph_select_six_o  = lat_a2_q;
        end else if (hold_i) begin
            periph_select_five_o = 1'b1;
            periph_select_six_o  = 1'b1;
        end else begin
            periph_select_five_o = ~sel5;
            periph_select_six_o  = ~sel6;
        end
    end
    assign ps5_oe_n_o = 1'b0;
    assign ps6_oe_n_o = 1'b0;

    // address phase quiet only when the strap allowed it
    assign addr_quiet_o = aden_q && cyc_q.lcs_ucs && cyc_q.quiet;

    // bus floated in T2 and T3; read strobe waits for that
    assign ad_float_o = (st_q == BCS_T2) || (st_q == BCS_T3);
    assign rd_n_o = ~(((st_q == BCS_T3) || ((st_q == BCS_T2) && ad_float_o))
                      && ((cyc_q.kind == BCS_ST_MEMRD) || (cyc_q.kind == BCS_ST_IORD)
                          || (cyc_q.kind == BCS_ST_FETCH)));
    assign rd_oe_n_o = hold_i;

    // status: kind from T1 until ready, passive otherwise
    assign status_low_o  = ((st_q == BCS_T1) || (st_q == BCS_T2) || (st_q == BCS_T3))
                           ? cyc_q.kind : BCS_ST_IDLE;
    assign status_oe_n_o = hold_i;

    // dma flag for T2 through T4
    assign dma_cycle_flag_o = cyc_q.dma && ((st_q == BCS_T2) || (st_q == BCS_T3)
                                            || (st_q == BCS_T4));
    assign dma_oe_n_o = hold_i || in_rst;

    // refresh two, idle high in PSRAM mode
    assign dram_refresh_two_low_o = ~(refresh_i && !psram_mode_i);
    assign refresh_two_oe_n_o     = hold_i || emu_tristate_i;

    // checks; multi-step cycle shapes are named sequences
    sequence seq_cycle_taken;
        st_q == BCS_IDLE && req_i.start && !hold_i && !in_rst;
    endsequence
    sequence seq_open_status;
        (st_q == BCS_T1 && status_low_o == $past(req_i.kind))
        ##1 (st_q == BCS_T2 && status_low_o == $past(req_i.kind, 2));
    endsequence
    sequence seq_wait_t3;
        st_q == BCS_T3 && !srdy_i && !ardy_i;
    endsequence
    chk_status_passive: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (st_q == BCS_T4) |-> status_low_o == BCS_ST_IDLE)
        else $error("status not passive at cycle end");
    chk_cycle_open: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        seq_cycle_taken |=> seq_open_status)
        else $error("status kind missing in T1 or T2");
    chk_dma_window: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (st_q == BCS_T1 && cyc_q.dma) |=> dma_cycle_flag_o)
        else $error("dma flag missing in T2");
    chk_dma_end: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (st_q == BCS_T4 && cyc_q.dma) |-> dma_cycle_flag_o)
        else $error("dma flag missing in T4");
    chk_sel_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (hold_i && aux_q[BCS_PIN_ROLE_BIT]) |-> periph_select_five_o && periph_select_six_o)
        else $error("select low during hold");
    chk_sel_reset: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        in_rst |-> periph_select_five_o && periph_select_six_o)
        else $error("select pin low during reset");
    chk_latch_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        hold_i |=> $stable(lat_a1_q) && $stable(lat_a2_q))
        else $error("latched address changed in hold");
    chk_rd_float: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !rd_n_o |-> ad_float_o)
        else $error("read strobe before bus float");
    chk_rd_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        hold_i |-> rd_oe_n_o && status_oe_n_o && dma_oe_n_o)
        else $error("pins driven during hold");
    chk_refresh_float: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (hold_i || emu_tristate_i) |-> refresh_two_oe_n_o)
        else $error("refresh pin driven in hold or tristate");
    chk_fetch_delay: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $fell(in_rst) |-> ##4 fetch_start_o)
        else $error("first fetch late or early");
    chk_sel_cycle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (aux_q[BCS_PIN_ROLE_BIT] && !periph_select_five_o) |-> busy_o)
        else $error("select outside cycle");
    chk_quiet_strap: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !aden_q |-> !addr_quiet_o)
        else $error("quiet address phase with strap low");
    chk_wait_ready: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        seq_wait_t3 |=> st_q == BCS_T3)
        else $error("cycle ended without ready");
endmodule : bcs_bus_ctrl

// >>> bench/bcs_mem_model.sv
// far-side memory and i/o model answering bus cycles with ready
`timescale 1ns/1ps
module bcs_mem_model (
    // clock and cycle view
    input  wire logic clk_sys_i,
    input  wire logic busy_i,
    input  wire logic slow_i,
    // ready answers
    output logic      srdy_o,
    output logic      ardy_o
);
    int wait_q;
    // cycles spent inside the current bus cycle, paces the slow answer
    always_ff @(posedge clk_sys_i) begin
        wait_q <= busy_i ? wait_q + 1 : 0;
    end
    // srdy is produced from the clock domain itself, so no sync is needed
    assign srdy_o = !slow_i;
    // slow device leaves srdy low and lets the async ready end the cycle late
    assign ardy_o = slow_i && (wait_q >= 4);
endmodule : bcs_mem_model

// >>> bench/bcs_bus_ctrl_tb.sv
// self-checking bench for the bus cycle status and control block
`timescale 1ns/1ps
module bcs_bus_ctrl_tb;
    import bcs_pkg::*;
    typedef struct packed {
        bcs_status_t kind;
        logic [19:0] addr;
        logic        ps5;
        logic        ps6;
    } bcs_row_t;
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    bcs_req_t    req = '0;
    logic        hold = 1'b0;
    logic        refresh = 1'b0;
    logic        psram = 1'b0;
    logic        emu = 1'b0;
    logic        slow = 1'b0;
    logic        aden = 1'b1;
    logic        half = 1'b1;
    logic        srdy, ardy, busy, fstart, half_clk, quiet, ps5, ps6, rd_n, rd_oe_n;
    logic        ad_float, st_oe_n, dma, dma_oe_n, rf2_n, rf2_oe_n;
    logic [19:0] faddr;
    logic [2:0]  st;
    int          bad_count = 0;
    int          tests_run = 0;
    int          n;
    bcs_row_t    rows [7] = '{
        '{BCS_ST_FETCH, 20'h0_0900, 1'b0, 1'b1}, '{BCS_ST_MEMRD, 20'h0_0A00, 1'b1, 1'b0},
        '{BCS_ST_MEMWR, 20'h0_09FF, 1'b0, 1'b1}, '{BCS_ST_IORD, 20'h0_0B00, 1'b1, 1'b1},
        '{BCS_ST_IOWR, 20'h0_08FF, 1'b1, 1'b1}, '{BCS_ST_INTA, 20'h0_0AFF, 1'b1, 1'b0},
        '{BCS_ST_HALT, 20'h0_0000, 1'b1, 1'b1}};

    // free-running system clock
    always #5 clk_sys_i = ~clk_sys_i;

    bcs_bus_ctrl i_dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .req_i(req),
        .hold_i(hold), .emu_tristate_i(emu), .refresh_i(refresh), .psram_mode_i(psram),
        .srdy_i(srdy), .ardy_i(ardy), .aden_strap_i(aden), .half_clock_strap_i(half),
        .busy_o(busy), .fetch_start_o(fstart), .fetch_addr_o(faddr), .half_clock_o(half_clk),
        .addr_quiet_o(quiet), .periph_select_five_o(ps5), .periph_select_six_o(ps6),
        .ps5_oe_n_o(), .ps6_oe_n_o(), .rd_n_o(rd_n), .rd_oe_n_o(rd_oe_n),
        .ad_float_o(ad_float), .status_low_o(st), .status_oe_n_o(st_oe_n),
        .dma_cycle_flag_o(dma), .dma_oe_n_o(dma_oe_n), .dram_refresh_two_low_o(rf2_n),
        .refresh_two_oe_n_o(rf2_oe_n)
    );

    bcs_mem_model i_mem (
        .clk_sys_i(clk_sys_i), .busy_i(busy), .slow_i(slow), .srdy_o(srdy), .ardy_o(ardy)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize();
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // register write, one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk_sys_i);
        reg_wr <= 1'b0;
    endtask : wr

    // register read, data only valid in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk_sys_i);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // launch a bus cycle and return settled inside t2
    task automatic cyc(input bcs_status_t k, input logic [19:0] a, input logic dm, input logic q);
        @(posedge clk_sys_i);
        req <= '{1'b1, k, a, dm, 1'b1, q};
        @(posedge clk_sys_i);
        req.start <= 1'b0;
        @(posedge clk_sys_i);
        #1;
    endtask : cyc

    // wait for the cycle to close, bounded
    task automatic drain();
        n = 0;
        while (busy !== 1'b0 && n < 40) begin
            @(posedge clk_sys_i);
            n++;
        end
        #1 chk(n < 40, 1);
    endtask : drain

    // reset held six cycles, then time the first fetch after release
    task automatic do_reset(input logic ad, input logic hf);
        @(posedge clk_sys_i);
        rst_i <= 1'b1; aden <= ad; half <= hf;
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (fstart !== 1'b1 && n < 30);
        chk(n, BCS_FETCH_CYC);
        chk(faddr, BCS_RESET_VEC);
        chk(half_clk, !hf);
    endtask : do_reset

    // hang guard, far above the expected run length
    initial begin
        #60000;
        bad_count++;
        summarize();
    end

    initial begin
        logic [15:0] d;
        @(posedge clk_sys_i);
        #1 chk({st, ps5, ps6}, {BCS_ST_IDLE, 2'b11});
        chk(dma_oe_n, 1);
        do_reset(1'b1, 1'b1);
        rd(BCS_OFF_AUX, d);
        chk(d, BCS_AUX_RST);
        wr(BCS_OFF_PBASE, 16'h0001);
        wr(BCS_OFF_AUX, 16'h0080);
        rd(BCS_OFF_PBASE, d);
        chk(d, 16'h0001);
        rd(8'h0C, d);
        chk(d, 16'h0000);
        $display("test registers done");
        // every status code but BCS_ST_IDLE, region boundaries of both selects
        foreach (rows[i]) begin
            cyc(rows[i].kind, rows[i].addr, 1'b0, 1'b0);
            chk(st, rows[i].kind);
            chk({ps5, ps6}, {rows[i].ps5, rows[i].ps6});
            drain();
            chk(st, BCS_ST_IDLE);
            chk({ps5, ps6}, 2'b11);
        end
        $display("test cycle table done");
        // slow dma read: async ready decides the end
        slow <= 1'b1;
        cyc(BCS_ST_MEMRD, 20'h1_0000, 1'b1, 1'b1);
        chk(dma, 1);
        chk({rd_n, ad_float}, 2'b01);
        chk(quiet, 1);
        repeat (2) @(posedge clk_sys_i);
        #1 chk(busy, 1);
        drain();
        slow <= 1'b0;
        $display("test slow dma done");
        // latched address bits on the select pins, then bus hold
        wr(BCS_OFF_AUX, 16'h0000);
        cyc(BCS_ST_IORD, 20'h0_0002, 1'b0, 1'b0);
        drain();
        chk({ps5, ps6}, 2'b10);
        @(posedge clk_sys_i);
        hold <= 1'b1;
        req <= '{1'b1, BCS_ST_MEMRD, 20'h0_0004, 1'b0, 1'b0, 1'b0};
        repeat (3) @(posedge clk_sys_i);
        #1 chk({ps5, ps6}, 2'b10);
        chk(busy, 0);
        chk({rd_oe_n, st_oe_n, rf2_oe_n}, 3'b111);
        chk(dma_oe_n, 1);
        req.start <= 1'b0;
        wr(BCS_OFF_AUX, 16'h0080);
        #1 chk({ps5, ps6}, 2'b11);
        @(posedge clk_sys_i);
        hold <= 1'b0;
        $display("test hold done");
        // refresh output follows the memory mode
        refresh <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1 chk(rf2_n, 0);
        chk(rf2_oe_n, 0);
        psram <= 1'b1;
        emu <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1 chk(rf2_n, 1);
        chk(rf2_oe_n, 1);
        refresh <= 1'b0;
        psram <= 1'b0;
        emu <= 1'b0;
        $display("test refresh done");
        // reset in mid-cycle abandons it at once
        slow <= 1'b1;
        cyc(BCS_ST_MEMWR, 20'h0_0900, 1'b1, 1'b1);
        rst_i <= 1'b1;
        #1 chk({busy, st}, {1'b0, BCS_ST_IDLE});
        chk({ps5, ps6, dma_oe_n}, 3'b111);
        slow <= 1'b0;
        do_reset(1'b0, 1'b0);
        cyc(BCS_ST_MEMRD, 20'h1_0000, 1'b0, 1'b1);
        chk(quiet, 0);
        drain();
        $display("test mid-cycle reset done");
        summarize();
    end
endmodule : bcs_bus_ctrl_tb
